// ===== core/ocs_fault_log.sv
// circular store of the twelve latest fault records
module ocs_fault_log (
   input wire logic sys_clk,
   input wire logic rst,
   ocs_log_if.store lg
);
   ocs_pkg::ocs_rec_t mem [ocs_pkg::LOG_DEPTH];
   logic [3:0] wrPtr_reg;
   logic [3:0] count_reg;

   function automatic logic [3:0] wrap(input logic [4:0] v);
      return (v >= 5'(ocs_pkg::LOG_DEPTH)) ?
             4'(v - 5'(ocs_pkg::LOG_DEPTH)) : v[3:0];
   endfunction : wrap

   // write oldest slot first, pointer wraps at twelve
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wrPtr_reg <= 4'h0;
         count_reg <= 4'h0;
      end else if (lg.wrEn) begin
         wrPtr_reg <= wrap(5'(wrPtr_reg) + 5'h01);
         if (count_reg != 4'(ocs_pkg::LOG_DEPTH))
            count_reg <= count_reg + 4'h1;
      end
   end

   // record storage, no reset needed for data
   always_ff @(posedge sys_clk) begin
      if (lg.wrEn) mem[wrPtr_reg] <= lg.wrRec;
   end

   // index 0 reads the newest record
   assign lg.rdRec = mem[wrap(5'(wrPtr_reg) + 5'(ocs_pkg::LOG_DEPTH - 1)
                              - 5'(lg.rdIdx))];
   assign lg.count = count_reg;
endmodule : ocs_fault_log

// ===== core/ocs_log_if.sv
// carrier between the stage and its fault record store
interface ocs_log_if;
   logic             wrEn;
   ocs_pkg::ocs_rec_t wrRec;
   logic [3:0]       rdIdx;
   ocs_pkg::ocs_rec_t rdRec;
   logic [3:0]       count;
   modport writer (output wrEn, wrRec, rdIdx, input rdRec, count);
   modport store  (input wrEn, wrRec, rdIdx, output rdRec, count);
endinterface : ocs_log_if

// ===== core/ocs_pickup.sv
// per-phase pick-up comparator with drop-off hysteresis
module ocs_pickup (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic [47:0] magFund,
   input  wire logic [47:0] magTrue,
   input  wire logic [47:0] magPp,
   input  wire logic [1:0]  magSel,
   input  wire logic [15:0] threshold,
   output logic [2:0]       pickPh,
   output logic [15:0]      maxMag
);
   logic [47:0] sel;
   logic [15:0] mx;

   // choose magnitude source, fundamental by default
   always_comb begin
      case (ocs_pkg::ocs_mag_t'(magSel))
         ocs_pkg::MAG_TRUE: sel = magTrue;
         ocs_pkg::MAG_PP:   sel = magPp;
         default:           sel = magFund;
      endcase
      mx = sel[15:0];
      for (int i = 1; i < 3; i++) begin
         if (sel[16*i +: 16] > mx) mx = sel[16*i +: 16];
      end
   end

   // set above threshold, clear below 97 percent of it
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pickPh <= 3'h0;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (sel[16*i +: 16] > threshold)
               pickPh[i] <= 1'b1;
            else if (24'(sel[16*i +: 16]) * 24'd100 <
                     24'(threshold) * 24'(ocs_pkg::RESET_PCT))
               pickPh[i] <= 1'b0;
         end
      end
   end

   // highest selected phase magnitude
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) maxMag <= 16'h0;
      else     maxMag <= mx;
   end
endmodule : ocs_pickup

// ===== core/ocs_pkg.sv
// constants, register map and types of the overcurrent stage
package ocs_pkg;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_HZ        = 10_000_000;
   localparam int PROG_CYCLE_US = 1000;     // one program cycle, also 1 ms
   localparam int PROG_CYCLES   = CLK_HZ / 1_000_000 * PROG_CYCLE_US;
   localparam int HIST_STEP_MS  = 10;       // history sample spacing
   localparam int PRE_TRIG_MS   = 20;
   localparam int PRE_FAULT_MS  = 200;
   localparam int PRE_TRIG_IDX  = PRE_TRIG_MS / HIST_STEP_MS;
   localparam int HIST_DEPTH    = PRE_FAULT_MS / HIST_STEP_MS + 1;
   localparam int MAX_REMAIN_MS = 1_800_000; // 1800 s
   localparam int RESET_PCT     = 97;        // drop-off ratio
   localparam int LOG_DEPTH     = 12;
   localparam int NUM_EVENTS    = 18;
   // ------------------------------------------------------------
   // register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_THRESH   = 8'h04;
   localparam logic [7:0] OFS_DELAY    = 8'h08;
   localparam logic [7:0] OFS_HARMLIM  = 8'h0c;
   localparam logic [7:0] OFS_EVMASK   = 8'h10;
   localparam logic [7:0] OFS_STATUS   = 8'h14;
   localparam logic [7:0] OFS_CNTSTART = 8'h18;
   localparam logic [7:0] OFS_CNTTRIP  = 8'h1c;
   localparam logic [7:0] OFS_CNTBLK   = 8'h20;
   localparam logic [7:0] OFS_REMAIN   = 8'h24;
   localparam logic [7:0] OFS_LOGSEL   = 8'h28;
   localparam logic [7:0] OFS_LOGTIME  = 8'h2c;
   localparam logic [7:0] OFS_LOGINFO  = 8'h30;
   localparam logic [7:0] OFS_LOGCUR   = 8'h34;
   localparam logic [7:0] OFS_LOGPRE   = 8'h38;
   localparam logic [7:0] OFS_LOGREM   = 8'h3c;
   // ctrl fields
   localparam int CTRL_INV   = 0;
   localparam int CTRL_INR   = 1;
   localparam int CTRL_MAG   = 2;  // two bits
   localparam int CTRL_GRP   = 4;  // three bits
   localparam int CTRL_CLR   = 7;  // write one clears counters
   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [15:0] RST_THRESH  = 16'h0078; // 1.20 x In, 0.01 step
   localparam logic [20:0] RST_DELAY   = 21'h0003e8;
   localparam logic [12:0] RST_HARMLIM = 13'h0001; // 0.01 %
   localparam logic [17:0] RST_EVMASK  = 18'h3ffff;
   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {MAG_FUND, MAG_TRUE, MAG_PP} ocs_mag_t;
   typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_BLOCKED} ocs_state_t;
   typedef enum logic [1:0] {REC_START, REC_TRIP, REC_BLOCK} ocs_recev_t;
   typedef struct packed {
      logic [31:0] stamp;
      ocs_recev_t  evKind;
      logic [2:0]  phases;
      logic [15:0] preTrig;
      logic [15:0] trigCur;
      logic [15:0] preFault;
      logic [20:0] remain;
      logic [2:0]  group;
   } ocs_rec_t;
endpackage : ocs_pkg

// ===== core/ocs_stage.sv
// overcurrent stage: blocking, start/trip, events, counters, fault log
//
// Decided for this implementation: the placing of the registers and the Wishbone register port.
module ocs_stage #(
   parameter int PROG_CYCLES = ocs_pkg::PROG_CYCLES
) (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        blockIn,
   input  wire logic [47:0] magFund,
   input  wire logic [47:0] magTrue,
   input  wire logic [47:0] magPp,
   input  wire logic [15:0] harmRatio,
   output logic             startOut,
   output logic             tripOut,
   output logic             blockedOut,
   output logic [2:0]       startPhases,
   output logic [2:0]       tripPhases,
   output logic             evValid,
   output logic [4:0]       evCode,
   output logic [31:0]      evTime
);
   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   ocs_log_if lg ();
   ocs_pkg::ocs_state_t st_reg;
   logic [31:0] ctrl_reg;
   logic [15:0] thresh_reg;
   logic [20:0] delay_reg, remain_reg;
   logic [12:0] harmLim_reg;
   logic [17:0] evMask_reg, pend_reg, pendSet, pendClr;
   logic [15:0] cntStart_reg, cntTrip_reg, cntBlk_reg;
   logic [3:0]  logSel_reg;
   logic [8:0]  flags, prevFl_reg, rise, fall;
   logic [2:0]  startPh_reg, tripPh_reg, pickPh;
   logic [15:0] maxMag, hist [ocs_pkg::HIST_DEPTH];
   logic [31:0] msCount_reg, stamp_reg;
   logic [13:0] div_reg;
   logic [3:0]  histDiv_reg;
   logic        tick, tickD_reg, blkS1_reg, blkS2_reg;
   logic        inrush, anyPick, wbReq, wbWr;
   logic [20:0] step;
   logic [4:0]  nextEv;

   // lowest set bit of a pending vector
   function automatic logic [4:0] firstBit(input logic [17:0] v);
      firstBit = 5'h1f;
      for (int i = ocs_pkg::NUM_EVENTS - 1; i >= 0; i--) begin
         if (v[i]) firstBit = 5'(i);
      end
   endfunction : firstBit

   // ------------------------------------------------------------
   // program cycle divider and timestamp
   // ------------------------------------------------------------
   assign tick = (div_reg == 14'(PROG_CYCLES - 1));

   // one-cycle tick per program cycle, millisecond clock
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         div_reg     <= 14'h0;
         msCount_reg <= 32'h0;
      end else if (tick) begin
         div_reg     <= 14'h0;
         msCount_reg <= msCount_reg + 32'h1;
      end else begin
         div_reg <= div_reg + 14'h1;
      end
   end

   // ------------------------------------------------------------
   // block input synchroniser and per-cycle sample
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         blkS1_reg <= 1'b0;
         blkS2_reg <= 1'b0;
      end else begin
         blkS1_reg <= blockIn;
         blkS2_reg <= blkS1_reg;
      end
   end

   // ------------------------------------------------------------
   // pick-up comparator
   // ------------------------------------------------------------
   ocs_pickup u_pickup (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .magFund   (magFund),
      .magTrue   (magTrue),
      .magPp     (magPp),
      .magSel    (ctrl_reg[ocs_pkg::CTRL_MAG +: 2]),
      .threshold (thresh_reg),
      .pickPh    (pickPh),
      .maxMag    (maxMag)
   );

   assign anyPick = |pickPh;
   // inrush blocks internal trip when enabled and over limit
   assign inrush  = ctrl_reg[ocs_pkg::CTRL_INR] &
                    (harmRatio > 16'(harmLim_reg));

   // inverse mode shortens by current multiple per program cycle
   always_comb begin
      step = 21'h1;
      if (ctrl_reg[ocs_pkg::CTRL_INV] && thresh_reg != 16'h0 &&
          maxMag > thresh_reg)
         step = 21'(maxMag / thresh_reg);
   end

   // ------------------------------------------------------------
   // start / trip / blocked sequence, advanced once per cycle
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_reg      <= ocs_pkg::ST_IDLE;
         remain_reg  <= 21'h0;
         startPh_reg <= 3'h0;
         tripPh_reg  <= 3'h0;
      end else if (tick) begin
         case (st_reg)
            ocs_pkg::ST_IDLE: begin
               // block is read only at the tick edge
               if (anyPick && blkS2_reg) begin
                  st_reg <= ocs_pkg::ST_BLOCKED;
               end else if (anyPick) begin
                  st_reg      <= ocs_pkg::ST_RUN;
                  remain_reg  <= delay_reg;
                  startPh_reg <= pickPh;
               end
            end
            ocs_pkg::ST_RUN: begin
               if (blkS2_reg || !anyPick) begin
                  st_reg      <= ocs_pkg::ST_IDLE;
                  remain_reg  <= 21'h0;
                  startPh_reg <= 3'h0;
                  tripPh_reg  <= 3'h0;
               end else begin
                  startPh_reg <= pickPh;
                  if (remain_reg > step)
                     remain_reg <= remain_reg - step;
                  else
                     remain_reg <= 21'h0;
                  if (remain_reg == 21'h0 && !inrush)
                     tripPh_reg <= pickPh;
               end
            end
            ocs_pkg::ST_BLOCKED: begin
               if (!anyPick) st_reg <= ocs_pkg::ST_IDLE;
            end
            default: st_reg <= ocs_pkg::ST_IDLE;
         endcase
      end
   end

   // overall start and trip outputs are the or of the phases
   assign startPhases = startPh_reg;
   assign tripPhases  = tripPh_reg;
   assign startOut    = |startPh_reg;
   assign tripOut     = |tripPh_reg;
   assign blockedOut  = (st_reg == ocs_pkg::ST_BLOCKED);

   // ------------------------------------------------------------
   // change detection, one cycle after the sequence moves
   // ------------------------------------------------------------
   assign flags = {tripPh_reg, startPh_reg, blockedOut, tripOut, startOut};
   assign rise  = tickD_reg ? (flags & ~prevFl_reg) : 9'h0;
   assign fall  = tickD_reg ? (~flags & prevFl_reg) : 9'h0;

   // previous flags and change stamp
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         tickD_reg  <= 1'b0;
         prevFl_reg <= 9'h0;
         stamp_reg  <= 32'h0;
      end else begin
         tickD_reg <= tick;
         if (tickD_reg) begin
            prevFl_reg <= flags;
            if (|(flags ^ prevFl_reg)) stamp_reg <= msCount_reg;
         end
      end
   end

   // ------------------------------------------------------------
   // event queue: even bit on, odd bit off
   // ------------------------------------------------------------
   always_comb begin
      for (int g = 0; g < 9; g++) begin
         pendSet[2*g]   = rise[g];
         pendSet[2*g+1] = fall[g];
      end
      nextEv  = firstBit(pend_reg);
      pendClr = 18'h0;
      if (nextEv != 5'h1f) pendClr[nextEv] = 1'b1;
   end

   // new changes win over the drain of the same bit
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) pend_reg <= 18'h0;
      else     pend_reg <= (pend_reg & ~pendClr) | pendSet;
   end

   // one event per clock, masked ones dropped silently
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         evValid <= 1'b0;
         evCode  <= 5'h0;
         evTime  <= 32'h0;
      end else begin
         evValid <= (nextEv != 5'h1f) && evMask_reg[nextEv];
         evCode  <= nextEv;
         evTime  <= stamp_reg;
      end
   end

   // ------------------------------------------------------------
   // cumulative counters
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cntStart_reg <= 16'h0;
         cntTrip_reg  <= 16'h0;
         cntBlk_reg   <= 16'h0;
      end else if (ctrl_reg[ocs_pkg::CTRL_CLR]) begin
         cntStart_reg <= 16'h0;
         cntTrip_reg  <= 16'h0;
         cntBlk_reg   <= 16'h0;
      end else begin
         if (rise[0]) cntStart_reg <= cntStart_reg + 16'h1;
         if (rise[1]) cntTrip_reg  <= cntTrip_reg + 16'h1;
         if (rise[2]) cntBlk_reg   <= cntBlk_reg + 16'h1;
      end
   end

   // ------------------------------------------------------------
   // current history every 10 ms, for pre-trigger and pre-fault
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         histDiv_reg <= 4'h0;
         for (int i = 0; i < ocs_pkg::HIST_DEPTH; i++) hist[i] <= 16'h0;
      end else if (tick) begin
         if (histDiv_reg == 4'(ocs_pkg::HIST_STEP_MS - 1)) begin
            histDiv_reg <= 4'h0;
            hist[0] <= maxMag;
            for (int i = 1; i < ocs_pkg::HIST_DEPTH; i++)
               hist[i] <= hist[i-1];
         end else begin
            histDiv_reg <= histDiv_reg + 4'h1;
         end
      end
   end

   // ------------------------------------------------------------
   // fault record on on-transitions, trip first
   // ------------------------------------------------------------
   assign lg.wrEn = rise[0] | rise[1] | rise[2];
   assign lg.wrRec.stamp    = msCount_reg;
   assign lg.wrRec.evKind   = rise[1] ? ocs_pkg::REC_TRIP :
                              rise[0] ? ocs_pkg::REC_START :
                                        ocs_pkg::REC_BLOCK;
   assign lg.wrRec.phases   = rise[2] ? pickPh :
                              (rise[1] ? tripPh_reg : startPh_reg);
   assign lg.wrRec.preTrig  = hist[ocs_pkg::PRE_TRIG_IDX];
   assign lg.wrRec.trigCur  = maxMag;
   assign lg.wrRec.preFault = hist[ocs_pkg::HIST_DEPTH - 1];
   assign lg.wrRec.remain   = remain_reg;
   assign lg.wrRec.group    = ctrl_reg[ocs_pkg::CTRL_GRP +: 3];
   assign lg.rdIdx          = logSel_reg;

   ocs_fault_log u_log (
      .sys_clk (sys_clk),
      .rst     (rst),
      .lg      (lg.store)
   );

   // ------------------------------------------------------------
   // wishbone classic slave, ack one cycle after request
   // ------------------------------------------------------------
   assign wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wbWr  = wbReq & wb_we_i & wb_sel_i[0];

   // writable settings; counter clear self-clears
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ctrl_reg    <= 32'h0;
         thresh_reg  <= ocs_pkg::RST_THRESH;
         delay_reg   <= ocs_pkg::RST_DELAY;
         harmLim_reg <= ocs_pkg::RST_HARMLIM;
         evMask_reg  <= ocs_pkg::RST_EVMASK;
         logSel_reg  <= 4'h0;
      end else begin
         ctrl_reg[ocs_pkg::CTRL_CLR] <= 1'b0;
         if (wbWr) begin
            case (wb_adr_i)
               ocs_pkg::OFS_CTRL:    ctrl_reg <= {24'h0, wb_dat_i[7:0]};
               ocs_pkg::OFS_THRESH:  thresh_reg  <= wb_dat_i[15:0];
               ocs_pkg::OFS_DELAY:   delay_reg   <= wb_dat_i[20:0];
               ocs_pkg::OFS_HARMLIM: harmLim_reg <= wb_dat_i[12:0];
               ocs_pkg::OFS_EVMASK:  evMask_reg  <= wb_dat_i[17:0];
               ocs_pkg::OFS_LOGSEL:  logSel_reg  <= wb_dat_i[3:0];
               default: ;
            endcase
         end
      end
   end

   // ack and read data; unmapped reads return zero
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= wbReq;
         if (wbReq) begin
            case (wb_adr_i)
               ocs_pkg::OFS_CTRL:     wb_dat_o <= {25'h0, ctrl_reg[6:0]};
               ocs_pkg::OFS_THRESH:   wb_dat_o <= {16'h0, thresh_reg};
               ocs_pkg::OFS_DELAY:    wb_dat_o <= {11'h0, delay_reg};
               ocs_pkg::OFS_HARMLIM:  wb_dat_o <= {19'h0, harmLim_reg};
               ocs_pkg::OFS_EVMASK:   wb_dat_o <= {14'h0, evMask_reg};
               ocs_pkg::OFS_STATUS:   wb_dat_o <= {22'h0, inrush, flags};
               ocs_pkg::OFS_CNTSTART: wb_dat_o <= {16'h0, cntStart_reg};
               ocs_pkg::OFS_CNTTRIP:  wb_dat_o <= {16'h0, cntTrip_reg};
               ocs_pkg::OFS_CNTBLK:   wb_dat_o <= {16'h0, cntBlk_reg};
               ocs_pkg::OFS_REMAIN:   wb_dat_o <= {11'h0, remain_reg};
               ocs_pkg::OFS_LOGSEL:
                  wb_dat_o <= {20'h0, lg.count, 4'h0, logSel_reg};
               ocs_pkg::OFS_LOGTIME:  wb_dat_o <= lg.rdRec.stamp;
               ocs_pkg::OFS_LOGINFO:
                  wb_dat_o <= {24'h0, lg.rdRec.group, lg.rdRec.phases,
                               lg.rdRec.evKind};
               ocs_pkg::OFS_LOGCUR:
                  wb_dat_o <= {lg.rdRec.trigCur, lg.rdRec.preTrig};
               ocs_pkg::OFS_LOGPRE:   wb_dat_o <= {16'h0, lg.rdRec.preFault};
               ocs_pkg::OFS_LOGREM:   wb_dat_o <= {11'h0, lg.rdRec.remain};
               default:               wb_dat_o <= 32'h0;
            endcase
         end
      end
   end
endmodule : ocs_stage

// ===== testbench/ocs_partner.sv
// blocking matrix and phase current source facing the stage
module ocs_partner (
   input  wire logic        blkReq,
   input  wire logic [2:0]  faultPh,
   input  wire logic [15:0] level,
   input  wire logic [15:0] harmReq,
   output logic             blockIn,
   output logic [47:0]      magFund,
   output logic [47:0]      magTrue,
   output logic [47:0]      magPp,
   output logic [15:0]      harmRatio
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [15:0] LOAD = 16'h0032;
   // block on its own line, ahead of the operate delay
   assign blockIn = blkReq;
   assign harmRatio = harmReq;
   // faulted phases carry the level, the others normal load
   assign magFund = {faultPh[2] ? level : LOAD, faultPh[1] ? level : LOAD,
                     faultPh[0] ? level : LOAD};
   // other sources sit high so a wrong source pick shows up
   assign magTrue = {3{16'hffff}};
   assign magPp = {3{16'hffff}};
endmodule : ocs_partner

// ===== testbench/ocs_stage_properties.sv
// concurrent checks on the ports of the overcurrent stage
module ocs_stage_properties #(
   parameter int PROG_CYCLES = 20
) (
   input wire logic       sys_clk,
   input wire logic       rst,
   input wire logic       wb_cyc_i,
   input wire logic       wb_stb_i,
   input wire logic       wb_ack_o,
   input wire logic       startOut,
   input wire logic       tripOut,
   input wire logic       blockedOut,
   input wire logic [2:0] startPhases,
   input wire logic [2:0] tripPhases,
   input wire logic       evValid,
   input wire logic [4:0] evCode
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // bus answer one edge after the take, one cycle long
   ack_next_edge_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("no ack after request");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   // stage outputs and their events
   start_or_a: assert property (startOut == (|startPhases))
      else $error("start differs from phase or");
   trip_or_a: assert property (tripOut == (|tripPhases))
      else $error("trip differs from phase or");
   start_blocked_a: assert property (!(startOut && blockedOut))
      else $error("start and blocked together");
   trip_start_a: assert property (tripOut |-> startOut)
      else $error("trip without start");
   hold_cycle_a: assert property ($changed(startOut) |=> $stable(startOut)[*8])
      else $error("start changed inside a program cycle");
   start_event_a: assert property ($rose(startOut) |-> ##[1:3] (evValid && evCode == 5'h00))
      else $error("start on event missing");
   stop_event_a: assert property ($fell(startOut) |-> ##[1:3] (evValid && evCode == 5'h01))
      else $error("start off event missing");
   cover property ($rose(tripOut));
   cover property ($rose(blockedOut));
   cover property (evValid && evCode == 5'h04);
endmodule : ocs_stage_properties

bind ocs_stage ocs_stage_properties #(.PROG_CYCLES(PROG_CYCLES)) chk_u (
   .sys_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .startOut, .tripOut,
   .blockedOut, .startPhases, .tripPhases, .evValid, .evCode);

// ===== testbench/tb.sv
// self-checking bench of the overcurrent stage
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int PC = 20;
   localparam int DLY = 3;
   logic sys_clk = 1'h0, rst = 1'h1, wbCyc = 1'h0, wbWe = 1'h0, blkReq = 1'h0;
   logic [7:0] wbAdr = 8'h00;
   logic [31:0] wbDat = 32'h0, rdData, q;
   logic wbAck, startOut, tripOut, blockedOut, blockIn;
   logic [2:0] startPhases, tripPhases, faultPh = 3'h0, ph;
   logic [15:0] level = 16'h0000, harmReq = 16'h0000, harmRatio;
   logic [47:0] magFund, magTrue, magPp;
   int nFail = 0, testsRun = 0, eS = 0, eT = 0, eB = 0;
   logic [7:0] rAdr[6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'hfc};
   logic [31:0] rVal[6] = '{32'h0, 32'h78, 32'h3e8, 32'h1, 32'h3ffff, 32'h0};
   ocs_partner far_u (.blkReq(blkReq), .faultPh(faultPh), .level(level),
      .harmReq(harmReq), .blockIn(blockIn), .magFund(magFund),
      .magTrue(magTrue), .magPp(magPp), .harmRatio(harmRatio));
   ocs_stage #(.PROG_CYCLES(PC)) dut_u (.sys_clk(sys_clk), .rst(rst),
      .wb_cyc_i(wbCyc), .wb_stb_i(wbCyc), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
      .wb_sel_i(4'hf), .wb_dat_i(wbDat), .wb_dat_o(rdData), .wb_ack_o(wbAck),
      .blockIn(blockIn), .magFund(magFund), .magTrue(magTrue), .magPp(magPp),
      .harmRatio(harmRatio), .startOut(startOut), .tripOut(tripOut),
      .blockedOut(blockedOut), .startPhases(startPhases),
      .tripPhases(tripPhases), .evValid(), .evCode(), .evTime());
   // clock source
   initial begin
      forever #50 sys_clk = ~sys_clk;
   end
   task automatic end_sim;
      $display("checks %0d, mismatches %0d", testsRun, nFail);
      if (nFail == 0 && testsRun > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_sim
   task automatic chk(input string what, input logic [31:0] exp, got);
      testsRun++;
      if (got !== exp) begin
         nFail++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk
   // one classic cycle, held until ack is sampled high
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int i;
      i = 0;
      wbCyc <= 1'h1;
      wbWe <= we;
      wbAdr <= a;
      wbDat <= d;
      do begin
         @(posedge sys_clk);
         i++;
      end while (wbAck !== 1'h1 && i < 50);
      q = rdData;
      wbCyc <= 1'h0;
      if (i >= 50) begin
         nFail++;
         end_sim();
      end
      @(posedge sys_clk);
   endtask : wb
   task automatic tick(input int n);
      repeat (n * PC) @(posedge sys_clk);
   endtask : tick
   task automatic outs(input string what, input logic [8:0] exp);
      chk(what, exp, {startPhases, tripPhases, startOut, tripOut, blockedOut});
   endtask : outs
   // main sequence
   initial begin
      void'($urandom(32'h0236d37c));
      repeat (20) @(posedge sys_clk);
      rst <= 1'h0;
      foreach (rAdr[k]) begin
         wb(1'h0, rAdr[k], 32'h0);
         chk("reset value", rVal[k], q);
      end
      $display("test reset values done");
      wb(1'h1, 8'h08, DLY);
      ph = 3'($urandom_range(7, 1));
      level <= 16'($urandom_range(999, 200));
      faultPh <= ph;
      tick(2);
      eS++;
      outs("start", {ph, 3'h0, 3'h4});
      tick(DLY + 2);
      eT++;
      outs("trip", {ph, ph, 3'h6});
      level <= 16'h0076;
      tick(2);
      outs("hold above reset ratio", {ph, ph, 3'h6});
      level <= 16'h0073;
      tick(2);
      outs("release below reset ratio", 9'h0);
      $display("test start trip release done");
      blkReq <= 1'h1;
      tick(2);
      faultPh <= 3'h1;
      level <= 16'h012c;
      tick(2);
      eB++;
      outs("blocked", 9'h1);
      faultPh <= 3'h0;
      blkReq <= 1'h0;
      tick(2);
      faultPh <= 3'h2;
      tick(2);
      eS++;
      blkReq <= 1'h1;
      tick(3);
      eB++;
      outs("block after start", 9'h1);
      faultPh <= 3'h0;
      blkReq <= 1'h0;
      tick(2);
      $display("test blocking done");
      wb(1'h1, 8'h00, 32'h2);
      wb(1'h1, 8'h0c, 32'h5dc);
      harmReq <= 16'h07d0;
      faultPh <= 3'h4;
      tick(DLY + 4);
      eS++;
      outs("inrush held", {3'h4, 3'h0, 3'h4});
      harmReq <= 16'h0000;
      tick(2);
      eT++;
      outs("inrush gone", {3'h4, 3'h4, 3'h6});
      faultPh <= 3'h0;
      tick(2);
      $display("test inrush done");
      wb(1'h0, 8'h18, 32'h0);
      chk("start count", eS, q);
      wb(1'h0, 8'h1c, 32'h0);
      chk("trip count", eT, q);
      wb(1'h0, 8'h20, 32'h0);
      chk("blocked count", eB, q);
      wb(1'h1, 8'h28, 32'h0);
      wb(1'h0, 8'h28, 32'h0);
      chk("record count", eS + eT + eB, q[11:8]);
      wb(1'h0, 8'h30, 32'h0);
      chk("newest record", 32'h1, q[1:0]);
      wb(1'h1, 8'h00, 32'h80);
      wb(1'h0, 8'h18, 32'h0);
      chk("cleared count", 32'h0, q);
      $display("test counters and log done");
      end_sim();
   end
endmodule : tb
